// ### dtr_steer_decode.v
// dual-tone receiver back end: pair check, early valid, steering, receive latch,
// delayed steering flag, open-drain interrupt and a small register port
// assumes limited comparator outputs and register strobes synchronous to clk;
// the steering level arrives from an outside threshold comparator and is resynchronised
//
// Contract
// - early valid goes high while a valid tone pair is seen and drops on any loss of it.
// - both tones are measured by counting and only the eight standard frequencies pass.
// - the registered pair is coded to four bits: 1-9 binary, 0 as 1010, star 1011, hash 1100, A-C 1101-1111, D 0000.
// - steering above threshold registers the pair; steering below frees the block for a new pair.
// - the guard output is high after registration while early valid stays high, a function of early valid and steering.
// - after a settling delay the delayed steering flag is set and shows in the status register.
// - in interrupt mode the open-drain interrupt is pulled low while the delayed steering flag is set.
// - the receive latch loads only on the active transition of delayed steering and otherwise holds.
// - a host read of the receive data register returns the latched code on the data lines.
// - short bursts are rejected and short dropouts tolerated without disturbing the latched data.
// - reading the status register clears the delayed steering status bit.
// - reading the status register releases the interrupt output.
`timescale 1ns/1ps
`default_nettype none
`include "dtr_map.vh"
module dtr_steer_decode #(
  parameter         CLK_HZ     = `DTR_CLK_HZ,
  parameter [127:0] LOW_FREQS  = `DTR_LOW_FREQS,
  parameter [127:0] HIGH_FREQS = `DTR_HIGH_FREQS,
  parameter         TOL_PPT    = `DTR_TOL_PPT,
  parameter         SETTLE_CYC = `DTR_SETTLE_CYC
) (
  input  wire                   clk,
  input  wire                   reset_n,
  input  wire                   lowToneIn,
  input  wire                   highToneIn,
  input  wire                   steerIn,
  output reg                    guardOut,
  output reg                    guardOe_n,
  output reg                    earlyPairValid,
  output reg                    irqOut,
  output reg                    irqOe_n,
  output reg                    eventIrq,
  input  wire [`DTR_ADDR_W-1:0] regAddr,
  input  wire [`DTR_DATA_W-1:0] regWdata,
  input  wire                   regWr,
  input  wire                   regRd,
  output reg  [`DTR_DATA_W-1:0] regRdata
);
  localparam [2:0] ST_FREE   = 3'b001;
  localparam [2:0] ST_SETTLE = 3'b010;
  localparam [2:0] ST_HELD   = 3'b100;
  localparam [7:0] SETTLE_W  = SETTLE_CYC[7:0];

  wire       lowValid;
  wire       highValid;
  wire [1:0] lowIdx;
  wire [1:0] highIdx;

  dtr_freq_meter #(
    .CLK_HZ  (CLK_HZ),
    .FREQS   (LOW_FREQS),
    .TOL_PPT (TOL_PPT),
    .CNT_W   (20)
  ) uLowMeter (
    .clk       (clk),
    .reset_n   (reset_n),
    .toneIn    (lowToneIn),
    .bandValid (lowValid),
    .bandIdx   (lowIdx)
  );

  dtr_freq_meter #(
    .CLK_HZ  (CLK_HZ),
    .FREQS   (HIGH_FREQS),
    .TOL_PPT (TOL_PPT),
    .CNT_W   (20)
  ) uHighMeter (
    .clk       (clk),
    .reset_n   (reset_n),
    .toneIn    (highToneIn),
    .bandValid (highValid),
    .bandIdx   (highIdx)
  );

  // row index lo and column index hi to the four-bit key code
  function [3:0] pairCode;
    input [1:0] lo;
    input [1:0] hi;
    begin
      if (hi == 2'h3) begin
        pairCode = (lo == 2'h3) ? 4'h0 : (4'hd + {2'h0, lo});
      end else if (lo == 2'h3) begin
        pairCode = (hi == 2'h0) ? 4'hb : (hi == 2'h1) ? 4'ha : 4'hc;
      end else begin
        pairCode = {2'h0, lo} + {2'h0, lo} + {2'h0, lo} + {2'h0, hi} + 4'h1;
      end
    end
  endfunction

  reg [2:0]             state_reg;
  reg [2:0]             state_next;
  reg [7:0]             settleCnt_reg;
  reg                   steerMeta_reg;
  reg                   steerSync_reg;
  reg                   steerSyncD_reg;
  reg [3:0]             pendCode_reg;
  reg [3:0]             rxData_reg;
  reg                   delaySteer_reg;
  reg                   delayFlag_reg;
  reg                   ctlIrqMode_reg;
  reg [`DTR_EV_W-1:0]   evStat_reg;
  reg [`DTR_EV_W-1:0]   evEnable_reg;
  reg                   earlyD_reg;

  wire earlyNext  = lowValid & highValid;
  wire steerRise  = steerSync_reg & ~steerSyncD_reg;
  wire settleDone = (state_reg == ST_SETTLE) && (settleCnt_reg == SETTLE_W);
  // delayed steering level stays low through settling, so this marks its active transition
  wire dsRise     = settleDone & ~delaySteer_reg;
  wire statusRd   = regRd && (regAddr == `DTR_OFF_STATUS);
  wire evClrWr    = regWr && (regAddr == `DTR_OFF_EVCLEAR);
  wire [`DTR_EV_W-1:0] evSet;
  assign evSet[`DTR_EV_NEWDATA] = dsRise;
  assign evSet[`DTR_EV_EARLY]   = earlyNext & ~earlyD_reg;

  // first stage feeds only the second
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      steerMeta_reg  <= 1'b0;
      steerSync_reg  <= 1'b0;
      steerSyncD_reg <= 1'b0;
    end else begin
      steerMeta_reg  <= steerIn;
      steerSync_reg  <= steerMeta_reg;
      steerSyncD_reg <= steerSync_reg;
    end
  end

  // the outside RC network does the duration checks; the sequence only follows its level,
  // so a burst that never lifts steering, or a dropout that never drops it, changes nothing
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_FREE: begin
        if (steerRise && earlyPairValid) begin
          state_next = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (settleDone) begin
          state_next = ST_HELD;
        end
      end
      ST_HELD: begin
        if (!steerSync_reg) begin
          state_next = ST_FREE;
        end
      end
      default: begin
        state_next = ST_FREE;
      end
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg      <= ST_FREE;
      settleCnt_reg  <= 8'h00;
      pendCode_reg   <= `DTR_RXDATA_RST;
      rxData_reg     <= `DTR_RXDATA_RST;
      delaySteer_reg <= 1'b0;
      earlyPairValid <= 1'b0;
      earlyD_reg     <= 1'b0;
      guardOut       <= 1'b0;
      guardOe_n      <= 1'b1;
    end else begin
      state_reg      <= state_next;
      earlyPairValid <= earlyNext;
      earlyD_reg     <= earlyNext;
      // guard drives the RC high only while the pair holds and steering is up
      guardOut       <= earlyNext & steerSync_reg;
      guardOe_n      <= 1'b0;
      if (state_reg == ST_FREE && state_next == ST_SETTLE) begin
        pendCode_reg <= pairCode(lowIdx, highIdx);
      end
      if (state_reg == ST_SETTLE) begin
        settleCnt_reg <= settleCnt_reg + 8'h01;
      end else begin
        settleCnt_reg <= 8'h00;
      end
      if (dsRise) begin
        rxData_reg <= pendCode_reg;
      end
      delaySteer_reg <= (state_next == ST_HELD);
    end
  end

  // set wins over a status read in the same cycle so no new pair is lost
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      delayFlag_reg <= 1'b0;
      evStat_reg    <= {`DTR_EV_W{1'b0}};
    end else begin
      if (dsRise) begin
        delayFlag_reg <= 1'b1;
      end else if (statusRd) begin
        delayFlag_reg <= 1'b0;
      end
      evStat_reg <= (evStat_reg & ~(evClrWr ? regWdata[`DTR_EV_W-1:0] : {`DTR_EV_W{1'b0}}))
                    | evSet;
    end
  end

  // open-drain pin: the pad is pulled low only while enabled, never driven high
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqOut   <= 1'b0;
      irqOe_n  <= 1'b1;
      eventIrq <= 1'b0;
    end else begin
      irqOut   <= 1'b0;
      // a status read that meets a new registration keeps the pin low, so no pair slips past
      irqOe_n  <= ~(ctlIrqMode_reg & (delayFlag_reg | dsRise) & ~(statusRd & ~dsRise));
      eventIrq <= |(((evStat_reg & ~(evClrWr ? regWdata[`DTR_EV_W-1:0] : {`DTR_EV_W{1'b0}}))
                    | evSet) & evEnable_reg);
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctlIrqMode_reg <= `DTR_CONTROL_RST;
      evEnable_reg   <= `DTR_EVENABLE_RST;
    end else if (regWr) begin
      if (regAddr == `DTR_OFF_CONTROL) begin
        ctlIrqMode_reg <= regWdata[`DTR_CTL_IRQMODE];
      end else if (regAddr == `DTR_OFF_EVENABLE) begin
        evEnable_reg <= regWdata[`DTR_EV_W-1:0];
      end
    end
  end

  // read data stands only in the cycle after the strobe; unmapped offsets read zero
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdata <= {`DTR_DATA_W{1'b0}};
    end else if (regRd) begin
      if (regAddr == `DTR_OFF_RXDATA) begin
        regRdata <= {4'h0, rxData_reg};
      end else if (regAddr == `DTR_OFF_STATUS) begin
        regRdata <= {4'h0, steerSync_reg, delayFlag_reg, earlyPairValid, ~irqOe_n};
      end else if (regAddr == `DTR_OFF_CONTROL) begin
        regRdata <= {7'h00, ctlIrqMode_reg};
      end else if (regAddr == `DTR_OFF_EVSTAT) begin
        regRdata <= {6'h00, evStat_reg};
      end else if (regAddr == `DTR_OFF_EVENABLE) begin
        regRdata <= {6'h00, evEnable_reg};
      end else begin
        regRdata <= {`DTR_DATA_W{1'b0}};
      end
    end else begin
      regRdata <= {`DTR_DATA_W{1'b0}};
    end
  end
endmodule // dtr_steer_decode
`default_nettype wire

// ### dtr_map.vh
// constants for the dual-tone receive steering block
// assumes a 250 MHz device clock and a byte-wide register port
`ifndef DTR_MAP_VH
`define DTR_MAP_VH

`define DTR_CLK_HZ        250000000
`define DTR_CLK_MHZ       250
`define DTR_LOW_FREQS     {32'd941, 32'd852, 32'd770, 32'd697}
`define DTR_HIGH_FREQS    {32'd1633, 32'd1477, 32'd1336, 32'd1209}
`define DTR_TOL_PPT       20
`define DTR_SETTLE_NS     40
`define DTR_SETTLE_CYC    ((`DTR_SETTLE_NS * `DTR_CLK_MHZ + 999) / 1000)

`define DTR_ADDR_W        3
`define DTR_DATA_W        8
`define DTR_OFF_RXDATA    3'h0
`define DTR_OFF_STATUS    3'h1
`define DTR_OFF_CONTROL   3'h2
`define DTR_OFF_EVSTAT    3'h3
`define DTR_OFF_EVCLEAR   3'h4
`define DTR_OFF_EVENABLE  3'h5

`define DTR_ST_IRQ_BIT    0
`define DTR_ST_EARLY_BIT  1
`define DTR_ST_DELAY_BIT  2
`define DTR_ST_STEER_BIT  3
`define DTR_CTL_IRQMODE   0
`define DTR_EV_NEWDATA    0
`define DTR_EV_EARLY      1
`define DTR_EV_W          2

`define DTR_CONTROL_RST   1'h0
`define DTR_EVENABLE_RST  2'h0
`define DTR_RXDATA_RST    4'h0

`endif

// ### dtr_freq_meter.v
// period meter for one limited tone comparator output, sorting it into one of four bands
// assumes the comparator output is synchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "dtr_map.vh"
module dtr_freq_meter #(
  parameter         CLK_HZ  = `DTR_CLK_HZ,
  parameter [127:0] FREQS   = `DTR_LOW_FREQS,
  parameter         TOL_PPT = `DTR_TOL_PPT,
  parameter         CNT_W   = 20
) (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       toneIn,
  output reg        bandValid,
  output reg  [1:0] bandIdx
);
  // longest legal period is that of the lowest band; twice it means the tone is gone
  localparam integer TMO = (CLK_HZ / FREQS[31:0]) * 2;
  wire [CNT_W-1:0] tmoCnt = TMO[CNT_W-1:0];

  reg              toneD_reg;
  reg  [CNT_W-1:0] cnt_reg;
  reg              prevHit_reg;
  reg  [1:0]       prevIdx_reg;
  wire [3:0]       match;
  wire             rise = toneIn & ~toneD_reg;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gBand
      localparam integer PER = CLK_HZ / FREQS[32*g +: 32];
      localparam integer LO  = PER - (PER * TOL_PPT) / 1000;
      localparam integer HI  = PER + (PER * TOL_PPT) / 1000;
      wire [CNT_W-1:0] loCnt = LO[CNT_W-1:0];
      wire [CNT_W-1:0] hiCnt = HI[CNT_W-1:0];
      assign match[g] = (cnt_reg >= loCnt) && (cnt_reg <= hiCnt);
    end
  endgenerate

  wire       hit    = |match;
  wire [1:0] hitIdx = match[3] ? 2'h3 : match[2] ? 2'h2 : match[1] ? 2'h1 : 2'h0;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      toneD_reg   <= 1'b0;
      cnt_reg     <= {CNT_W{1'b0}};
      prevHit_reg <= 1'b0;
      prevIdx_reg <= 2'h0;
      bandValid   <= 1'b0;
      bandIdx     <= 2'h0;
    end else begin
      toneD_reg <= toneIn;
      if (rise) begin
        cnt_reg     <= {{(CNT_W-1){1'b0}}, 1'b1};
        prevHit_reg <= hit;
        prevIdx_reg <= hitIdx;
        // two matching periods in a row before the band counts, against stray edges
        if (hit && prevHit_reg && (hitIdx == prevIdx_reg)) begin
          bandValid <= 1'b1;
          bandIdx   <= hitIdx;
        end else begin
          bandValid <= 1'b0;
        end
      end else if (cnt_reg >= tmoCnt) begin
        prevHit_reg <= 1'b0;
        bandValid   <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // dtr_freq_meter
`default_nettype wire

// ### dtr_steer_checker.sv
// port assertions for the steering decode block
// assumes one clock domain and the dtr_map.vh offsets
`timescale 1ns/1ps
`default_nettype none
`include "dtr_map.vh"
module dtr_steer_checker (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       lowToneIn,
  input wire logic       steerIn,
  input wire logic       guardOut,
  input wire logic       guardOe_n,
  input wire logic       earlyPairValid,
  input wire logic       irqOe_n,
  input wire logic       regRd,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regRdata
);
  int   quiet_reg;
  logic lowLast_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // idle cycles of the low comparator, saturating so it stays small
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      quiet_reg   <= 0;
      lowLast_reg <= 1'b0;
    end else begin
      lowLast_reg <= lowToneIn;
      quiet_reg   <= (lowToneIn != lowLast_reg) ? 0 : quiet_reg + 32'(quiet_reg < 4000);
    end
  end
  sequence s_stat_rd;
    regRd && regAddr == `DTR_OFF_STATUS;
  endsequence
  property p_quiet; quiet_reg > 1000 |-> !earlyPairValid; endproperty
  a_quiet: assert property (p_quiet) else $error("early valid without tone");
  property p_guard;
    guardOut |-> earlyPairValid && ($past(steerIn, 2) || $past(steerIn, 3));
  endproperty
  a_guard: assert property (p_guard) else $error("guard high without cause");
  property p_drive; $past(reset_n) |-> !guardOe_n; endproperty
  a_drive: assert property (p_drive) else $error("guard pin not driven");
  property p_idle; !$past(regRd) |-> regRdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read slot");
  property p_clr; s_stat_rd ##2 s_stat_rd |=> !regRdata[2]; endproperty
  a_clr: assert property (p_clr) else $error("flag survived status read");
  property p_rel; s_stat_rd and !irqOe_n |=> irqOe_n; endproperty
  a_rel: assert property (p_rel) else $error("irq held after status read");
  property p_irqbit; s_stat_rd |=> regRdata[0] == !$past(irqOe_n); endproperty
  a_irqbit: assert property (p_irqbit) else $error("status irq bit wrong");
  property p_early; s_stat_rd |=> regRdata[1] == $past(earlyPairValid); endproperty
  a_early: assert property (p_early) else $error("status early bit wrong");
  property p_late; $fell(irqOe_n) |-> $past(steerIn, 10); endproperty
  a_late: assert property (p_late) else $error("irq before settled steering");
endmodule // dtr_steer_checker
bind dtr_steer_decode dtr_steer_checker chk (.clk, .reset_n, .lowToneIn, .steerIn,
  .guardOut, .guardOe_n, .earlyPairValid, .irqOe_n, .regRd, .regAddr, .regRdata);
`default_nettype wire

// ### dtr_rc_partner.sv
// tone comparators and rc steering node outside the block
// assumes tone periods in device clock cycles
`timescale 1ns/1ps
`default_nettype none
module dtr_rc_partner #(
  parameter int TH   = 500,
  parameter int FULL = 1500
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        toneOn,
  input  wire logic [15:0] lowPer,
  input  wire logic [15:0] highPer,
  input  wire logic        earlyPairValid,
  input  wire logic        guardOut,
  input  wire logic        guardOe_n,
  output var  logic        lowToneIn,
  output var  logic        highToneIn,
  output var  logic        steerIn
);
  int lowCnt, highCnt, cap;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {lowCnt, highCnt, cap} <= '0;
      {lowToneIn, highToneIn, steerIn} <= '0;
    end else begin
      lowCnt     <= (!toneOn || lowCnt + 1 >= lowPer) ? 0 : lowCnt + 1;
      highCnt    <= (!toneOn || highCnt + 1 >= highPer) ? 0 : highCnt + 1;
      lowToneIn  <= toneOn && lowCnt < lowPer / 2;
      highToneIn <= toneOn && highCnt < highPer / 2;
      if (!guardOe_n && guardOut) cap <= FULL;
      else if (earlyPairValid) cap <= (cap < FULL) ? cap + 1 : cap;
      else cap <= (cap > 0) ? cap - 1 : 0;
      // slow decay is what makes short dropouts harmless
      steerIn <= cap >= TH;
    end
  end
endmodule // dtr_rc_partner
`default_nettype wire

// ### tb_dtr_steer_decode.sv
// self-checking bench for the steering decode block
// assumes dtr_map.vh and a 100 kHz clock figure to keep tone periods short
`timescale 1ns/1ps
`default_nettype none
`include "dtr_map.vh"
module tb_dtr_steer_decode;
  localparam int CLK_HZ = 100000;
  localparam int LOWF[4] = '{697, 770, 852, 941};
  localparam int HIGHF[4] = '{1209, 1336, 1477, 1633};
  localparam logic [7:0] WEXP[8] = '{8'h0, 8'h0, 8'h1, 8'h0, 8'h0, 8'h3, 8'h0, 8'h0};
  logic        clk, reset_n, lowToneIn, highToneIn, steerIn, toneOn, regWr, regRd;
  logic        guardOut, guardOe_n, earlyPairValid, irqOut, irqOe_n, eventIrq;
  logic [2:0]  regAddr;
  logic [7:0]  regWdata, regRdata, rdv;
  logic [15:0] lowPer, highPer;
  logic [3:0]  expQ[$];
  logic [3:0]  lastCode, idx, start;
  logic [31:0] rng;
  int          numErrors, nChecks;
  dtr_steer_decode #(.CLK_HZ(CLK_HZ)) uut (.clk, .reset_n, .lowToneIn, .highToneIn,
    .steerIn, .guardOut, .guardOe_n, .earlyPairValid, .irqOut, .irqOe_n, .eventIrq,
    .regAddr, .regWdata, .regWr, .regRd, .regRdata);
  dtr_rc_partner far (.clk, .reset_n, .toneOn, .lowPer, .highPer, .earlyPairValid,
    .guardOut, .guardOe_n, .lowToneIn, .highToneIn, .steerIn);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  function automatic logic [3:0] codeOf(input int r, input int c);
    if (c == 3) return (r == 3) ? 4'h0 : 4'(13 + r);
    if (r == 3) return (c == 0) ? 4'hb : ((c == 1) ? 4'ha : 4'hc);
    return 4'(r * 3 + c + 1);
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    nChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rdv = regRdata;
  endtask
  task automatic tone(input int r, input int c, input logic on);
    @(posedge clk);
    lowPer  <= 16'((CLK_HZ + LOWF[r] / 2) / LOWF[r]);
    highPer <= 16'((CLK_HZ + HIGHF[c] / 2) / HIGHF[c]);
    toneOn  <= on;
  endtask
  // bounded wait on the irq pin or the steering level
  task automatic waitOn(input bit onSteer, input logic lvl);
    int n;
    for (n = 0; n < 4000; n++) begin
      @(negedge clk);
      if ((onSteer ? steerIn : irqOe_n) === lvl) break;
    end
    if (n == 4000) begin
      numErrors++;
      $display("mismatch wait expected %b seen timeout", lvl);
      conclude();
    end
  endtask
  task automatic regTone(input int r, input int c);
    tone(r, c, 1'b1);
    expQ.push_back(codeOf(r, c));
    waitOn(1'b0, 1'b0);
    chk("eventIrq", 8'h1, {7'h0, eventIrq});
    chk("irqOut", 8'h0, {7'h0, irqOut});
    repeat (rng[5:0]) @(posedge clk);
    rd(`DTR_OFF_STATUS);
    chk("status", 8'h0f, rdv);
    chk("irqOe_n", 8'h1, {7'h0, irqOe_n});
    rd(`DTR_OFF_STATUS);
    chk("status", 8'h0a, rdv);
    lastCode = expQ.pop_front();
    rd(`DTR_OFF_RXDATA);
    chk("rxdata", {4'h0, lastCode}, rdv);
    rd(`DTR_OFF_EVSTAT);
    chk("evstat", 8'h03, rdv);
    wr(`DTR_OFF_EVCLEAR, 8'h03);
    rd(`DTR_OFF_EVSTAT);
    chk("evstat", 8'h00, rdv);
    chk("eventIrq", 8'h0, {7'h0, eventIrq});
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {reset_n, toneOn, regWr, regRd, regAddr, regWdata} = '0;
    {numErrors, nChecks} = '0;
    lowPer = 16'd100;
    highPer = 16'd50;
    rng = 32'hacfb;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a));
      chk("reset value", 8'h00, rdv);
      wr(3'(a), 8'hff);
    end
    for (int a = 0; a < 8; a++) begin
      rd(3'(a));
      if (a != `DTR_OFF_EVCLEAR) chk("access", WEXP[a], rdv);
    end
    $display("test registers done");
    rng = xs(rng);
    start = rng[3:0];
    for (int k = 0; k < 16; k++) begin
      rng = xs(rng);
      idx = start + 4'(k * 5);
      regTone(idx[3:2], idx[1:0]);
      tone(idx[3:2], idx[1:0], 1'b0);
      waitOn(1'b1, 1'b0);
    end
    $display("test digits done");
    wr(`DTR_OFF_EVENABLE, 8'h00);
    // drain the rc node first so that only the burst itself can charge it
    repeat (600) @(posedge clk);
    tone(0, 0, 1'b1);
    repeat (400 + rng[7:0] % 200) @(posedge clk);
    tone(0, 0, 1'b0);
    repeat (1500) @(posedge clk);
    @(negedge clk);
    chk("eventIrq", 8'h0, {7'h0, eventIrq});
    rd(`DTR_OFF_EVSTAT);
    chk("evstat", 8'h02, rdv);
    rd(`DTR_OFF_RXDATA);
    chk("rxdata", {4'h0, lastCode}, rdv);
    wr(`DTR_OFF_EVENABLE, 8'h03);
    rd(`DTR_OFF_STATUS);
    chk("eventIrq", 8'h1, {7'h0, eventIrq});
    wr(`DTR_OFF_EVCLEAR, 8'h03);
    $display("test short burst done");
    regTone(2, 3);
    tone(2, 3, 1'b0);
    repeat (600) @(posedge clk);
    tone(2, 3, 1'b1);
    repeat (1000) @(posedge clk);
    @(negedge clk);
    chk("irqOe_n", 8'h1, {7'h0, irqOe_n});
    rd(`DTR_OFF_STATUS);
    chk("status", 8'h0a, rdv);
    rd(`DTR_OFF_RXDATA);
    chk("rxdata", {4'h0, lastCode}, rdv);
    $display("test dropout done");
    conclude();
  end
endmodule // tb_dtr_steer_decode
`default_nettype wire
